// ==== hdl/ebc_pkg.sv ====
// Package of encodings and timing constants for the external bus cycle
// control block.
// Assumes a single 100 MHz clock shared by every user of the package.
package ebc_pkg;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [1:0] EBC_SIZE_LONG = 2'h0;
    localparam logic [1:0] EBC_SIZE_BYTE = 2'h1;
    localparam logic [1:0] EBC_SIZE_WORD = 2'h2;
    localparam logic [1:0] EBC_SIZE_LINE = 2'h3;

    localparam logic [1:0] EBC_KIND_NORMAL = 2'h0;
    localparam logic [1:0] EBC_KIND_DMA    = 2'h1;
    localparam logic [1:0] EBC_KIND_DEBUG  = 2'h2;
    localparam logic [1:0] EBC_KIND_CPU    = 2'h3;

    localparam logic [1:0] EBC_WIDTH_32 = 2'h0;
    localparam logic [1:0] EBC_WIDTH_8  = 2'h1;
    localparam logic [1:0] EBC_WIDTH_16 = 2'h2;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [3:0] EBC_BOOT_WAIT_STATES = 4'hF;
    localparam logic [3:0] EBC_WAIT_RESET       = 4'h0;
    localparam int         EBC_CLOCK_MHZ        = 100;
    localparam int         EBC_DRAM_TIME_NS     = 60;
    localparam int         EBC_DRAM_CYCLES      =
        (EBC_DRAM_TIME_NS * EBC_CLOCK_MHZ + 999) / 1000;
    localparam logic [3:0] EBC_DRAM_COUNT = 4'(EBC_DRAM_CYCLES);

endpackage

// ==== hdl/ebc_sync.sv ====
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is held at least one clock period.
`timescale 1ns/1ps
`default_nettype none
module ebc_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ebc_wait_counter.sv ====
// Down counter that times wait states and DRAM transfers.
// Assumes load and run come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module ebc_wait_counter #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // Control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             run,
    output logic                  expired
);
    logic [WIDTH-1:0] count_q;

    assign expired = run && (count_q == '0) && !load;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
        end else if (load) begin
            count_q <= load_value;
        end else if (run && count_q != '0) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ebc_bus_control.sv ====
// Bus cycle controller of the external bus: starts and ends own cycles and
// answers alternate-master cycles to chip selects and DRAM.
// Assumes the bus control pins are sampled by two flip-flops here and data by one register; the user side is
// on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_control
    import ebc_pkg::*;
#(
    parameter int DATA_WIDTH = 32,
    parameter int ADDR_WIDTH = 32
) (
    // Clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    // User request side
    input  wire logic                      req_valid,
    input  wire logic                      req_read,
    input  wire logic [1:0]                req_size,
    input  wire logic [1:0]                req_kind,
    input  wire logic                      req_code,
    input  wire logic                      req_super,
    input  wire logic                      req_ctrl_move,
    input  wire logic                      req_dram,
    input  wire logic [ADDR_WIDTH-1:0]     req_addr,
    input  wire logic [DATA_WIDTH-1:0]     req_wdata,
    output logic                           req_ready,
    output logic                           done_valid,
    output logic                           done_error,
    output logic [DATA_WIDTH-1:0]          done_rdata,
    // Ownership and alternate-master target decode
    input  wire logic                      bus_owned,
    input  wire logic                      alt_hit_chip_select,
    input  wire logic                      alt_hit_dram,
    input  wire logic [3:0]                alt_wait_states,
    input  wire logic                      altmaster_auto_ack,
    // Boot chip-select configuration
    input  wire logic                      boot_autoack_strap,
    input  wire logic                      boot_width_strap_hi,
    input  wire logic                      boot_width_strap_lo,
    input  wire logic                      cfg_write,
    input  wire logic                      cfg_auto_acknowledge,
    input  wire logic [1:0]                cfg_port_width,
    input  wire logic [3:0]                cfg_wait_states,
    output logic                           boot_auto_acknowledge,
    output logic [1:0]                     boot_port_width,
    output logic [3:0]                     boot_wait_states,
    // Bus pins, three signals each where two-way
    output logic [ADDR_WIDTH-1:0]          addr_out,
    output logic                           addr_oe,
    input  wire logic                      read_write_in,
    output logic                           read_write_out,
    input  wire logic [1:0]                xfer_size_in,
    output logic [1:0]                     xfer_size_out,
    output logic [1:0]                     xfer_kind,
    output logic                           access_modifier,
    output logic                           ctrl_oe,
    input  wire logic                      transfer_start_n_in,
    output logic                           transfer_start_n_out,
    output logic                           transfer_start_oe,
    input  wire logic                      sync_xfer_ack_n_in,
    output logic                           sync_xfer_ack_n_out,
    output logic                           sync_xfer_ack_oe,
    input  wire logic                      async_xfer_ack_n,
    input  wire logic                      xfer_error_ack_n,
    input  wire logic [DATA_WIDTH-1:0]     data_in,
    output logic [DATA_WIDTH-1:0]          data_out,
    output logic                           data_oe,
    // Alternate-master memory control
    output logic                           alt_chip_select_n,
    output logic                           alt_dram_select_n,
    output logic                           alt_is_read,
    output logic [3:0]                     alt_lane_n
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic       ta_n_s;
    logic       ata_n_s;
    logic       tea_n_s;
    logic       ts_n_s;
    logic       rw_s;
    logic [1:0] siz_s;
    logic [2:0] strap_s;

    ebc_sync u_sync_ta (.clock(clock), .rstn(rstn),
        .async_in(sync_xfer_ack_n_in), .sync_out(ta_n_s));
    ebc_sync u_sync_ata (.clock(clock), .rstn(rstn),
        .async_in(async_xfer_ack_n), .sync_out(ata_n_s));
    ebc_sync u_sync_tea (.clock(clock), .rstn(rstn),
        .async_in(xfer_error_ack_n), .sync_out(tea_n_s));
    ebc_sync u_sync_ts (.clock(clock), .rstn(rstn),
        .async_in(transfer_start_n_in), .sync_out(ts_n_s));
    ebc_sync u_sync_rw (.clock(clock), .rstn(rstn),
        .async_in(read_write_in), .sync_out(rw_s));

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_siz
            ebc_sync #(.RESET_VALUE(1'b0)) u_sync_siz (.clock(clock),
                .rstn(rstn), .async_in(xfer_size_in[gi]),
                .sync_out(siz_s[gi]));
        end
    endgenerate

    ebc_sync u_sync_s2 (.clock(clock), .rstn(rstn),
        .async_in(boot_autoack_strap), .sync_out(strap_s[2]));
    ebc_sync u_sync_s1 (.clock(clock), .rstn(rstn),
        .async_in(boot_width_strap_hi), .sync_out(strap_s[1]));
    ebc_sync u_sync_s0 (.clock(clock), .rstn(rstn),
        .async_in(boot_width_strap_lo), .sync_out(strap_s[0]));

    // ************************************************************
    // Boot chip-select configuration
    // ************************************************************
    // Straps are caught once the synchronisers carry them, since an
    // asynchronous reset may only load constants.
    logic [1:0] strap_wait_q;
    logic       boot_aa_q;
    logic [1:0] boot_width_q;
    logic [3:0] boot_wait_q;
    logic       strap_take;
    logic [1:0] strap_width;

    assign strap_take  = (strap_wait_q == 2'h2);
    assign strap_width = (strap_s[1:0] == 2'h0) ? EBC_WIDTH_32 :
                         (strap_s[1:0] == 2'h1) ? EBC_WIDTH_8 :
                                                  EBC_WIDTH_16;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strap_wait_q <= 2'h0;
        end else if (!strap_take) begin
            strap_wait_q <= strap_wait_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            boot_aa_q    <= 1'b0;
            boot_width_q <= EBC_WIDTH_32;
            boot_wait_q  <= EBC_WAIT_RESET;
        end else if (strap_take && !strap_done_q) begin
            boot_aa_q    <= strap_s[2];
            boot_width_q <= strap_width;
            boot_wait_q  <= strap_s[2] ? EBC_BOOT_WAIT_STATES
                                       : EBC_WAIT_RESET;
        end else if (cfg_write) begin
            boot_aa_q    <= cfg_auto_acknowledge;
            boot_width_q <= cfg_port_width;
            boot_wait_q  <= cfg_wait_states;
        end
    end

    // The counter parks at 2, so this flag keeps the strap load one-shot.
    logic strap_done_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strap_done_q <= 1'b0;
        end else if (strap_take) begin
            strap_done_q <= 1'b1;
        end
    end

    assign boot_auto_acknowledge = boot_aa_q;
    assign boot_port_width       = boot_width_q;
    assign boot_wait_states      = boot_wait_q;

    // ************************************************************
    // Own bus cycles
    // ************************************************************
    typedef enum logic [1:0] {EBC_IDLE, EBC_START, EBC_WAIT} ebc_state_t;
    ebc_state_t state_q;

    logic        dram_q;
    logic        read_q;
    logic [1:0]  kind_q;
    logic        code_q;
    logic        super_q;
    logic        ctrl_move_q;
    logic [3:0]  dram_count_q;
    logic        start_cycle;
    logic        ack_sync;
    logic        ack_async;
    logic        ack_error;
    logic        ack_dram;
    logic        cycle_end;
    logic        ata_prev_q;
    logic        ata_fall;
    logic        mod_start;
    logic        mod_later;

    assign start_cycle = (state_q == EBC_IDLE) && req_valid && bus_owned
                         && strap_done_q;
    assign ack_error = !tea_n_s && !dram_q;
    assign ack_sync  = !ta_n_s && !dram_q;
    assign ata_fall  = !ata_n_s && ata_prev_q;
    assign ack_async = ata_fall && !dram_q;
    assign ack_dram  = dram_q && (dram_count_q == 4'h0);
    assign cycle_end = (state_q == EBC_WAIT)
                       && (ack_error || ack_sync || ack_async || ack_dram);

    // Modifier in the start clock and in the clocks that follow.
    assign mod_start = (kind_q == EBC_KIND_DMA) ? 1'b1 :
                       (kind_q == EBC_KIND_CPU) ? !ctrl_move_q :
                       code_q;
    assign mod_later = (kind_q == EBC_KIND_DMA || kind_q == EBC_KIND_CPU)
                       ? 1'b0 : super_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= EBC_IDLE;
        end else begin
            unique case (state_q)
                EBC_IDLE:  if (start_cycle) state_q <= EBC_START;
                EBC_START: state_q <= EBC_WAIT;
                EBC_WAIT:  if (cycle_end) state_q <= EBC_IDLE;
            endcase
        end
    end

    // Request fields are held for the whole cycle.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dram_q      <= 1'b0;
            read_q      <= 1'b1;
            kind_q      <= EBC_KIND_NORMAL;
            code_q      <= 1'b0;
            super_q     <= 1'b0;
            ctrl_move_q <= 1'b0;
            addr_out    <= '0;
            xfer_size_out <= EBC_SIZE_LONG;
            data_out    <= '0;
        end else if (start_cycle) begin
            dram_q      <= req_dram;
            read_q      <= req_read;
            kind_q      <= req_kind;
            code_q      <= req_code;
            super_q     <= req_super;
            ctrl_move_q <= req_ctrl_move;
            addr_out    <= req_addr;
            xfer_size_out <= req_size;
            data_out    <= req_wdata;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dram_count_q <= 4'h0;
        end else if (start_cycle) begin
            dram_count_q <= EBC_DRAM_COUNT;
        end else if (dram_count_q != 4'h0) begin
            dram_count_q <= dram_count_q - 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ata_prev_q <= 1'b1;
        end else begin
            ata_prev_q <= ata_n_s;
        end
    end

    // Pin drives.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            transfer_start_n_out <= 1'b1;
            transfer_start_oe    <= 1'b0;
            ctrl_oe              <= 1'b0;
            addr_oe              <= 1'b0;
            data_oe              <= 1'b0;
            read_write_out       <= 1'b1;
            xfer_kind            <= EBC_KIND_NORMAL;
            access_modifier      <= 1'b0;
        end else begin
            transfer_start_n_out <= !start_cycle;
            transfer_start_oe    <= bus_owned;
            ctrl_oe              <= bus_owned;
            addr_oe              <= bus_owned;
            // Write data stays driven until the ending edge.
            data_oe  <= bus_owned && (start_cycle ? !req_read
                        : (state_q != EBC_IDLE && !cycle_end && !read_q));
            read_write_out  <= start_cycle ? req_read : read_q;
            xfer_kind       <= start_cycle ? req_kind : kind_q;
            access_modifier <= (state_q == EBC_START) ? mod_later :
                               (state_q == EBC_IDLE && start_cycle) ?
                               ((req_kind == EBC_KIND_DMA) ? 1'b1 :
                                (req_kind == EBC_KIND_CPU) ? !req_ctrl_move :
                                req_code) : access_modifier;
        end
    end

    // Read data are taken at the edge where the cycle ends.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done_valid <= 1'b0;
            done_error <= 1'b0;
            done_rdata <= '0;
        end else begin
            done_valid <= cycle_end;
            done_error <= cycle_end && ack_error;
            if (cycle_end && read_q && !ack_error) begin
                done_rdata <= data_in;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_q == EBC_IDLE) && !start_cycle
                         && bus_owned && strap_done_q;
        end
    end

    // ************************************************************
    // Alternate-master cycles
    // ************************************************************
    // Kind and modifier pins are never sampled here.
    logic       alt_active_q;
    logic       alt_dram_q;
    logic       alt_start;
    logic       alt_wait_done;
    logic       alt_ack;
    logic [3:0] alt_load;
    logic [3:0] lane_n;

    assign alt_start = !bus_owned && !ts_n_s && !alt_active_q
                       && (alt_hit_chip_select || alt_hit_dram);
    assign alt_load  = alt_hit_dram ? EBC_DRAM_COUNT : alt_wait_states;
    assign alt_ack   = alt_active_q && alt_wait_done
                       && (alt_dram_q || altmaster_auto_ack);

    ebc_wait_counter #(.WIDTH(4)) u_alt_wait (
        .clock      (clock),
        .rstn       (rstn),
        .load       (alt_start),
        .load_value (alt_load),
        .run        (alt_active_q),
        .expired    (alt_wait_done)
    );

    // Byte lane strobes from size and the low address: longword and line
    // use all lanes, word two, byte one.
    assign lane_n = (siz_s == EBC_SIZE_BYTE) ? ~(4'h8 >> addr_out[1:0]) :
                    (siz_s == EBC_SIZE_WORD) ?
                        (addr_out[1] ? 4'hC : 4'h3) :
                    4'h0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            alt_active_q        <= 1'b0;
            alt_dram_q          <= 1'b0;
            alt_chip_select_n   <= 1'b1;
            alt_dram_select_n   <= 1'b1;
            alt_is_read         <= 1'b1;
            alt_lane_n          <= 4'hF;
            sync_xfer_ack_n_out <= 1'b1;
            sync_xfer_ack_oe    <= 1'b0;
        end else if (alt_start) begin
            alt_active_q      <= 1'b1;
            alt_dram_q        <= alt_hit_dram;
            alt_chip_select_n <= alt_hit_dram;
            alt_dram_select_n <= !alt_hit_dram;
            alt_is_read       <= rw_s;
            alt_lane_n        <= lane_n;
            sync_xfer_ack_oe  <= alt_hit_dram || altmaster_auto_ack;
        end else if (alt_active_q) begin
            sync_xfer_ack_n_out <= !(alt_ack && sync_xfer_ack_n_out);
            if (!sync_xfer_ack_n_out || bus_owned) begin
                alt_active_q      <= 1'b0;
                alt_chip_select_n <= 1'b1;
                alt_dram_select_n <= 1'b1;
                alt_lane_n        <= 4'hF;
            end
        end else begin
            sync_xfer_ack_n_out <= 1'b1;
            sync_xfer_ack_oe    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ==== verification/ebc_bus_control_sva.sv ====
// Checker of the bus cycle outputs of ebc_bus_control.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_control_sva (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rstn,
    // Watched ports
    input wire logic       transfer_start_n_out,
    input wire logic       transfer_start_oe,
    input wire logic [1:0] xfer_kind,
    input wire logic [1:0] xfer_size_out,
    input wire logic       read_write_out,
    input wire logic       access_modifier,
    input wire logic       done_valid,
    input wire logic       done_error,
    input wire logic       sync_xfer_ack_oe,
    input wire logic       bus_owned
);
    import ebc_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_start_one_clock: assert property (
        $fell(transfer_start_n_out) |=> transfer_start_n_out)
        else $error("start strobe longer than one clock");
    a_start_driven: assert property (
        !transfer_start_n_out |-> transfer_start_oe)
        else $error("start strobe low while not driven");
    a_ctrl_held: assert property (
        $rose(transfer_start_n_out) |-> $stable(xfer_kind)
        && $stable(xfer_size_out) && $stable(read_write_out))
        else $error("cycle attributes moved");
    a_done_pulse: assert property (
        done_valid |=> !done_valid)
        else $error("completion pulse longer than one clock");
    a_error_done: assert property (
        done_error |-> done_valid)
        else $error("error flag without completion");
    a_dma_modifier: assert property (
        !transfer_start_n_out && xfer_kind == EBC_KIND_DMA
        |-> access_modifier ##1 !access_modifier)
        else $error("DMA modifier wrong");
    a_cpu_modifier: assert property (
        !transfer_start_n_out && xfer_kind == EBC_KIND_CPU
        |=> !access_modifier)
        else $error("CPU space modifier high");
    a_alt_ack_only: assert property (
        sync_xfer_ack_oe |-> !bus_owned)
        else $error("ack driven while owner");
endmodule
bind ebc_bus_control ebc_bus_control_sva ebc_bus_control_sva_inst (.*);
`default_nettype wire

// ==== verification/ebc_slave_model.sv ====
// Slave on the far side: one acknowledge of two clocks per start strobe.
// Assumes it sees the start wire only while the device owns the bus.
`timescale 1ns/1ps
`default_nettype none
module ebc_slave_model #(
    parameter logic [31:0] WORD = 32'h0
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Bus side
    input  wire logic        start_n,
    input  wire logic        use_async,
    input  wire logic        slow,
    output logic             sync_ack_n,
    output logic             async_ack_n,
    output logic [31:0]      data
);
    logic [3:0] cnt_q;
    logic       ack_w;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 4'h0;
        end else if (!start_n) begin
            cnt_q <= slow ? 4'hE : 4'h6;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    // Acknowledge lasts two clocks, data two more.
    assign ack_w       = cnt_q == 4'h4 || cnt_q == 4'h3;
    assign sync_ack_n  = !(ack_w && !use_async);
    assign async_ack_n = !(ack_w && use_async);
    // Released lines show the inverse word so stale data cannot match.
    assign data = (cnt_q != 4'h0 && cnt_q < 4'h5) ? WORD : ~WORD;
endmodule
`default_nettype wire

// ==== verification/tb_ebc_bus_control.sv ====
// Bench of ebc_bus_control against the slave model, rows then corner cases.
// Assumes the design answers each request within forty clocks.
`timescale 1ns/1ps
`default_nettype none
module tb_ebc_bus_control;
    import ebc_pkg::*;
    localparam logic [31:0] WORD = 32'h5A3C_96E1;
    localparam logic [31:0] WDAT = 32'h1234_ABCD;
    typedef struct packed {
        logic [1:0] kind;
        logic       code, sup, cm, rd;
        logic [1:0] size;
        logic       asy, am0, am1;
    } ebc_row_t;
    ebc_row_t rows [6] = '{
        '{EBC_KIND_NORMAL, 1, 1, 0, 1, EBC_SIZE_LONG, 0, 1, 1},
        '{EBC_KIND_NORMAL, 0, 0, 0, 0, EBC_SIZE_BYTE, 1, 0, 0},
        '{EBC_KIND_DEBUG, 0, 1, 0, 1, EBC_SIZE_WORD, 1, 0, 1},
        '{EBC_KIND_DMA, 0, 0, 0, 1, EBC_SIZE_LINE, 0, 1, 0},
        '{EBC_KIND_CPU, 0, 1, 1, 0, EBC_SIZE_LONG, 0, 0, 0},
        '{EBC_KIND_CPU, 0, 1, 0, 1, EBC_SIZE_BYTE, 1, 1, 0}};
    logic clock = 0, rstn = 0, req_valid = 0, req_read = 0, req_code = 0;
    logic req_super = 0, req_ctrl_move = 0, req_dram = 0, bus_owned = 1;
    logic alt_hit_chip_select = 0, alt_hit_dram = 0, altmaster_auto_ack = 1;
    logic boot_autoack_strap = 0, boot_width_strap_hi = 0, cfg_write = 0;
    logic boot_width_strap_lo = 0, cfg_auto_acknowledge = 0, asy = 0;
    logic xfer_error_ack_n = 1, slow = 0, alt_ts_n = 1, alt_rw = 1;
    logic [1:0] req_size = 0, req_kind = 0, cfg_port_width = 0, alt_size = 0;
    logic [3:0] alt_wait_states = 4'h2, cfg_wait_states = 4'h3;
    logic [31:0] req_addr = 32'h0000_0100, req_wdata = WDAT;
    int error_cnt = 0, total_checks = 0, n;
    wire logic req_ready, done_valid, done_error, boot_auto_acknowledge;
    wire logic addr_oe, read_write_out, access_modifier, ctrl_oe, data_oe;
    wire logic transfer_start_n_out, transfer_start_oe, sync_xfer_ack_n_out;
    wire logic sync_xfer_ack_oe, alt_chip_select_n, alt_dram_select_n;
    wire logic alt_is_read, async_xfer_ack_n, slv_ack_n;
    wire logic [1:0] boot_port_width, xfer_size_out, xfer_kind;
    wire logic [3:0] boot_wait_states, alt_lane_n;
    wire logic [31:0] done_rdata, addr_out, data_out, slv_data;
    wire logic transfer_start_n_in = transfer_start_oe ? transfer_start_n_out
                                                       : alt_ts_n;
    wire logic sync_xfer_ack_n_in = sync_xfer_ack_oe ? sync_xfer_ack_n_out
                                                     : slv_ack_n;
    wire logic read_write_in = ctrl_oe ? read_write_out : alt_rw;
    wire logic [1:0] xfer_size_in = ctrl_oe ? xfer_size_out : alt_size;
    wire logic [31:0] data_in = data_oe ? data_out : slv_data;
    ebc_bus_control ebc_bus_control_inst (.*);
    ebc_slave_model #(.WORD(WORD)) ebc_slave_model_inst (.clock, .rstn,
        .start_n(transfer_start_n_in | !bus_owned), .use_async(asy), .slow,
        .sync_ack_n(slv_ack_n), .async_ack_n(async_xfer_ack_n),
        .data(slv_data));
    always #5 clock = ~clock;
    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] g, e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic cyc();
        @(posedge clock);
        #1;
    endtask
    // A wait that runs past its bound closes the run as a failure.
    task automatic step(inout int k);
        cyc();
        k++;
        if (k > 40) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic do_reset(input logic a, hi, lo, input logic [1:0] w);
        rstn = 0;
        boot_autoack_strap = a;
        boot_width_strap_hi = hi;
        boot_width_strap_lo = lo;
        repeat (12) cyc();
        chk("start oe", transfer_start_oe, 0);
        rstn = 1;
        repeat (4) cyc();
        chk("boot aa", boot_auto_acknowledge, a);
        if (a) chk("boot ws", boot_wait_states, EBC_BOOT_WAIT_STATES);
        chk("boot width", boot_port_width, w);
    endtask
    task automatic run(input ebc_row_t r, input logic dram, err);
        int k;
        k = 0;
        req_kind = r.kind;
        req_code = r.code;
        req_super = r.sup;
        req_ctrl_move = r.cm;
        req_read = r.rd;
        req_size = r.size;
        req_dram = dram;
        asy = r.asy;
        chk("ready", req_ready, 1);
        req_valid = 1;
        while (transfer_start_n_out !== 1'b0) step(k);
        xfer_error_ack_n = !err;
        chk("kind", xfer_kind, r.kind);
        chk("size", xfer_size_out, r.size);
        chk("dir", read_write_out, r.rd);
        chk("addr", addr_out, req_addr);
        chk("mod start", access_modifier, r.am0);
        req_valid = 0;
        k = 0;
        step(k);
        chk("mod late", access_modifier, r.am1);
        if (!r.rd) chk("wdata", data_oe ? data_out : ~WDAT, WDAT);
        while (done_valid !== 1'b1) step(k);
        xfer_error_ack_n = 1;
        chk("error", done_error, err);
        if (r.rd && !err) chk("rdata", done_rdata, WORD);
        if (dram) chk("dram time", k >= EBC_DRAM_CYCLES, 1);
        repeat (14) cyc();
    endtask
    initial begin
        do_reset(1, 1, 0, EBC_WIDTH_16);
        foreach (rows[i]) run(rows[i], 0, 0);
        run(rows[0], 1, 0);
        run(rows[1], 1, 0);
        slow = 1;
        run(rows[2], 0, 1);
        slow = 0;
        cfg_port_width = EBC_WIDTH_8;
        cfg_write = 1;
        chk("width held", boot_port_width, EBC_WIDTH_16);
        cyc();
        cfg_write = 0;
        repeat (2) cyc();
        chk("width cfg", boot_port_width, EBC_WIDTH_8);
        bus_owned = 0;
        alt_hit_chip_select = 1;
        alt_size = EBC_SIZE_BYTE;
        repeat (3) cyc();
        alt_ts_n = 0;
        cyc();
        alt_ts_n = 1;
        n = 0;
        while (sync_xfer_ack_n_out !== 1'b0) step(n);
        chk("alt ack oe", sync_xfer_ack_oe, 1);
        chk("alt cs", alt_chip_select_n, 0);
        chk("alt dir", alt_is_read, 1);
        chk("alt lanes", alt_lane_n, 4'h7);
        repeat (6) cyc();
        alt_hit_chip_select = 0;
        bus_owned = 1;
        do_reset(0, 0, 1, EBC_WIDTH_8);
        do_reset(0, 0, 0, EBC_WIDTH_32);
        end_of_test();
    end
endmodule
`default_nettype wire
